//--- iwd_pkg.sv
// iwd_pkg: shared constants of the independent watchdog
// assumes: 32-bit ahb-lite register port, slow oscillator sampled on CLK_IN
package iwd_pkg;
    // ------------------------------------------------------------
    // register word indices (byte offset = index * 4)
    // ------------------------------------------------------------
    localparam logic [1:0] WATCHDOG_COMMAND_IDX = 2'h0; // offset 0x0
    localparam logic [1:0] DIVIDER_SELECT_IDX = 2'h1;   // offset 0x4
    localparam logic [1:0] RELOAD_VALUE_IDX = 2'h2;     // offset 0x8
    localparam logic [1:0] UPDATE_STATUS_IDX = 2'h3;    // offset 0xc
    localparam int IDX_LSB = 2;
    localparam int MAP_MSB = 11;
    localparam int MAP_LSB = 4;
    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int CMD_W = 16;
    localparam int DIV_W = 3;
    localparam int CNT_W = 12;
    localparam int PRE_W = 8;
    localparam int RELOAD_BUSY_BIT = 1;
    localparam int DIVIDER_BUSY_BIT = 0;
    localparam logic [DIV_W-1:0] DIVIDER_RESET = 3'h0;
    localparam logic [CNT_W-1:0] RELOAD_RESET = 12'hfff;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 12'h000;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_UNLOCK = 16'h5555;
    localparam logic [CMD_W-1:0] CMD_START = 16'hcccc;
    localparam logic [CMD_W-1:0] CMD_RELOAD = 16'haaaa;
    // ------------------------------------------------------------
    // ahb-lite encodings
    // ------------------------------------------------------------
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_LOW = 2'h1;
    localparam logic [1:0] LANES_HIGH = 2'h2;
    localparam logic [1:0] LANES_BOTH = 2'h3;
endpackage

//--- iwd_reg_if.sv
// iwd_reg_if: register access strobes between bus front end and core
// assumes: one clock, write strobe lasts one cycle per write
`timescale 1ns/100ps
interface iwd_reg_if;
    logic wr_en;          // write data phase, one cycle
    logic hit;            // address inside the register map
    logic [1:0] idx;      // word index of the access
    logic [1:0] lanes;    // half-word lanes written
    logic [31:0] wdata;
    logic [31:0] rdata;   // read value of idx, combinational
    modport bus (output wr_en, output hit, output idx, output lanes, output wdata, input rdata);
    modport regs (input wr_en, input hit, input idx, input lanes, input wdata, output rdata);
endinterface

//--- iwd_ahb_slave.sv
// iwd_ahb_slave: ahb-lite slave front end, single transfers only
// assumes: hsel decodes the block's 4 KB page, hready is our hreadyout
`timescale 1ns/100ps
module iwd_ahb_slave (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // ahb-lite slave port
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // register side
    iwd_reg_if.bus rif
);
    logic wr_ph_r, wr_ph_nxt;
    logic rd_ph_r, rd_ph_nxt;
    logic rd_done_r, rd_done_nxt;
    logic hit_r, hit_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [1:0] lanes_r, lanes_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic accept;

    // reads take one wait state so a write just before is seen
    assign hreadyout_out = ~(rd_ph_r & ~rd_done_r);
    assign hresp_out = iwd_pkg::HRESP_OKAY;
    assign hrdata_out = hrdata_r;
    assign accept = hsel_in & htrans_in[1] & hready_in;
    assign rif.wr_en = wr_ph_r;
    assign rif.hit = hit_r;
    assign rif.idx = idx_r;
    assign rif.lanes = lanes_r;
    assign rif.wdata = hwdata_in;

    // address phase capture and read wait state
    always_comb begin
        wr_ph_nxt = wr_ph_r;
        rd_ph_nxt = rd_ph_r;
        rd_done_nxt = rd_done_r;
        hit_nxt = hit_r;
        idx_nxt = idx_r;
        lanes_nxt = lanes_r;
        hrdata_nxt = hrdata_r;
        if (hreadyout_out) begin
            wr_ph_nxt = accept & hwrite_in;
            rd_ph_nxt = accept & ~hwrite_in;
            rd_done_nxt = 1'b0;
            if (accept) begin
                hit_nxt = (haddr_in[iwd_pkg::MAP_MSB:iwd_pkg::MAP_LSB] == 8'h00);
                idx_nxt = haddr_in[iwd_pkg::IDX_LSB+1:iwd_pkg::IDX_LSB];
                // byte and misaligned accesses write nothing
                if (hsize_in == iwd_pkg::HSIZE_WORD && haddr_in[1:0] == 2'h0) begin
                    lanes_nxt = iwd_pkg::LANES_BOTH;
                end else if (hsize_in == iwd_pkg::HSIZE_HALF && !haddr_in[0]) begin
                    lanes_nxt = haddr_in[1] ? iwd_pkg::LANES_HIGH : iwd_pkg::LANES_LOW;
                end else begin
                    lanes_nxt = iwd_pkg::LANES_NONE;
                end
            end
        end else begin
            rd_done_nxt = 1'b1;
            hrdata_nxt = rif.rdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            rd_done_r <= 1'b0;
            hit_r <= 1'b0;
            idx_r <= 2'h0;
            lanes_r <= 2'h0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_ph_r <= wr_ph_nxt;
            rd_ph_r <= rd_ph_nxt;
            rd_done_r <= rd_done_nxt;
            hit_r <= hit_nxt;
            idx_r <= idx_nxt;
            lanes_r <= lanes_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end
endmodule

//--- iwd_prescaler.sv
// iwd_prescaler: eight-stage selectable divider of slow-oscillator edges
// assumes: step is a one-cycle pulse per slow-oscillator rising edge
`timescale 1ns/100ps
module iwd_prescaler (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic step_in,
    input wire logic clear_in,
    input wire logic [iwd_pkg::DIV_W-1:0] code_in,
    // output
    output logic tick_out
);
    logic [iwd_pkg::PRE_W-1:0] stage_r, stage_nxt;
    logic [iwd_pkg::PRE_W-1:0] mask;

    // codes 6 and 7 both give divide by 256, others 4 << code
    always_comb begin
        case (code_in)
            3'h0: mask = 8'h03;
            3'h1: mask = 8'h07;
            3'h2: mask = 8'h0f;
            3'h3: mask = 8'h1f;
            3'h4: mask = 8'h3f;
            3'h5: mask = 8'h7f;
            default: mask = 8'hff;
        endcase
    end

    assign tick_out = step_in & ((stage_r & mask) == mask);

    // the stages keep counting; only the masked low part matters
    always_comb begin
        stage_nxt = stage_r;
        if (clear_in) begin
            stage_nxt = 8'h00;
        end else if (step_in) begin
            stage_nxt = stage_r + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_r <= 8'h00;
        end else begin
            stage_r <= stage_nxt;
        end
    end
endmodule

//--- iwd_watchdog.sv
// iwd_watchdog: independent watchdog with ahb-lite registers
// assumes: CLK_IN at 10 MHz, SLOW_OSC_IN is the 40 kHz oscillator already
// synchronous to CLK_IN, WDG_RESET_OUT feeds the system reset controller
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module iwd_watchdog (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // ahb-lite slave port
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // slow oscillator and option strap
    input wire logic SLOW_OSC_IN,
    input wire logic HW_WDG_OPT_IN,
    // debug
    input wire logic CORE_HALTED_IN,
    input wire logic DEBUG_FREEZE_IN,
    // system reset request and state
    output logic WDG_RESET_OUT,
    output logic WDG_RUNNING_OUT
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    iwd_reg_if rif ();

    logic osc_q_r, osc_q_nxt;
    logic opt_seen_r, opt_seen_nxt;
    logic enabled_r, enabled_nxt;
    logic unlock_r, unlock_nxt;
    logic [iwd_pkg::DIV_W-1:0] div_code_r, div_code_nxt;
    logic [iwd_pkg::DIV_W-1:0] div_shadow_r, div_shadow_nxt;
    logic div_busy_r, div_busy_nxt;
    logic [iwd_pkg::CNT_W-1:0] reload_r, reload_nxt;
    logic [iwd_pkg::CNT_W-1:0] reload_shadow_r, reload_shadow_nxt;
    logic reload_busy_r, reload_busy_nxt;
    logic [iwd_pkg::CNT_W-1:0] count_r, count_nxt;
    logic reset_req_r, reset_req_nxt;

    logic wr_low;
    logic [iwd_pkg::CMD_W-1:0] cmd_code;
    logic cmd_wr;
    logic cmd_start;
    logic cmd_reload;
    logic div_wr;
    logic reload_wr;
    logic osc_edge;
    logic frozen;
    logic run;
    logic pre_tick;

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    iwd_ahb_slave u_bus (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .hsel_in(HSEL_IN),
        .haddr_in(HADDR_IN),
        .htrans_in(HTRANS_IN),
        .hwrite_in(HWRITE_IN),
        .hsize_in(HSIZE_IN),
        .hwdata_in(HWDATA_IN),
        .hready_in(HREADY_IN),
        .hrdata_out(HRDATA_OUT),
        .hreadyout_out(HREADYOUT_OUT),
        .hresp_out(HRESP_OUT),
        .rif(rif.bus)
    );

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // every live field sits in the low half, so a half-word write at
    // offset +2 lands only on reserved bits and changes nothing
    assign wr_low = rif.wr_en & rif.hit & rif.lanes[0];
    assign cmd_code = rif.wdata[iwd_pkg::CMD_W-1:0];
    assign cmd_wr = wr_low & (rif.idx == iwd_pkg::WATCHDOG_COMMAND_IDX);
    assign cmd_start = cmd_wr & (cmd_code == iwd_pkg::CMD_START);
    assign cmd_reload = cmd_wr & (cmd_code == iwd_pkg::CMD_RELOAD);
    // protected registers only take data while unlocked
    assign div_wr = wr_low & unlock_r & (rif.idx == iwd_pkg::DIVIDER_SELECT_IDX);
    assign reload_wr = wr_low & unlock_r & (rif.idx == iwd_pkg::RELOAD_VALUE_IDX);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // the command register is write-only and reads as zero; while a
    // busy flag is up the protected registers show the pending value
    always_comb begin
        rif.rdata = 32'h0000_0000;
        if (rif.hit) begin
            case (rif.idx)
                iwd_pkg::DIVIDER_SELECT_IDX: begin
                    rif.rdata[iwd_pkg::DIV_W-1:0] = div_shadow_r;
                end
                iwd_pkg::RELOAD_VALUE_IDX: begin
                    rif.rdata[iwd_pkg::CNT_W-1:0] = reload_shadow_r;
                end
                iwd_pkg::UPDATE_STATUS_IDX: begin
                    rif.rdata[iwd_pkg::RELOAD_BUSY_BIT] = reload_busy_r;
                    rif.rdata[iwd_pkg::DIVIDER_BUSY_BIT] = div_busy_r;
                end
                default: begin
                    rif.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // slow oscillator edge and run condition
    // ------------------------------------------------------------
    // the counter only moves on slow-oscillator rising edges, so its
    // rate is independent of the main clock frequency
    assign osc_edge = SLOW_OSC_IN & ~osc_q_r;
    assign frozen = CORE_HALTED_IN & DEBUG_FREEZE_IN;
    assign run = enabled_r & ~frozen;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // a reload restarts the prescaler so the full period follows it
    iwd_prescaler u_pre (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .step_in(osc_edge & run),
        .clear_in(cmd_reload | cmd_start),
        .code_in(div_code_r),
        .tick_out(pre_tick)
    );

    // ------------------------------------------------------------
    // control state: enable, unlock, option strap
    // ------------------------------------------------------------
    // enable can only be cleared by reset; the strap is looked at
    // once, in the first cycle after reset release
    always_comb begin
        osc_q_nxt = SLOW_OSC_IN;
        opt_seen_nxt = 1'b1;
        enabled_nxt = enabled_r;
        unlock_nxt = unlock_r;
        if (!opt_seen_r && HW_WDG_OPT_IN) begin
            enabled_nxt = 1'b1;
        end
        if (cmd_start) begin
            enabled_nxt = 1'b1;
        end
        if (cmd_wr) begin
            unlock_nxt = (cmd_code == iwd_pkg::CMD_UNLOCK);
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            osc_q_r <= 1'b0;
            opt_seen_r <= 1'b0;
            enabled_r <= 1'b0;
            unlock_r <= 1'b0;
        end else begin
            osc_q_r <= osc_q_nxt;
            opt_seen_r <= opt_seen_nxt;
            enabled_r <= enabled_nxt;
            unlock_r <= unlock_nxt;
        end
    end

    // ------------------------------------------------------------
    // divider select: shadow, busy, apply on slow edge
    // ------------------------------------------------------------
    // a write in the same cycle as the slow edge keeps busy set and
    // takes the newest value on the following edge
    always_comb begin
        div_shadow_nxt = div_shadow_r;
        div_busy_nxt = div_busy_r;
        div_code_nxt = div_code_r;
        if (div_wr) begin
            div_shadow_nxt = rif.wdata[iwd_pkg::DIV_W-1:0];
            div_busy_nxt = 1'b1;
        end else if (div_busy_r && osc_edge) begin
            div_code_nxt = div_shadow_r;
            div_busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            div_shadow_r <= iwd_pkg::DIVIDER_RESET;
            div_busy_r <= 1'b0;
            div_code_r <= iwd_pkg::DIVIDER_RESET;
        end else begin
            div_shadow_r <= div_shadow_nxt;
            div_busy_r <= div_busy_nxt;
            div_code_r <= div_code_nxt;
        end
    end

    // ------------------------------------------------------------
    // reload value: shadow, busy, apply on slow edge
    // ------------------------------------------------------------
    always_comb begin
        reload_shadow_nxt = reload_shadow_r;
        reload_busy_nxt = reload_busy_r;
        reload_nxt = reload_r;
        if (reload_wr) begin
            reload_shadow_nxt = rif.wdata[iwd_pkg::CNT_W-1:0];
            reload_busy_nxt = 1'b1;
        end else if (reload_busy_r && osc_edge) begin
            reload_nxt = reload_shadow_r;
            reload_busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reload_shadow_r <= iwd_pkg::RELOAD_RESET;
            reload_busy_r <= 1'b0;
            reload_r <= iwd_pkg::RELOAD_RESET;
        end else begin
            reload_shadow_r <= reload_shadow_nxt;
            reload_busy_r <= reload_busy_nxt;
            reload_r <= reload_nxt;
        end
    end

    // ------------------------------------------------------------
    // down-counter and reset request
    // ------------------------------------------------------------
    // reload uses the applied reload value; a value still crossing
    // counts only from the next reload onward
    always_comb begin
        count_nxt = count_r;
        if (cmd_reload) begin
            count_nxt = reload_r;
        end else if (pre_tick && count_r != iwd_pkg::COUNT_ZERO) begin
            count_nxt = count_r - 12'h001;
        end
        // held while the count sits at zero, until a reload command or the system resets us
        reset_req_nxt = enabled_r & (count_r == iwd_pkg::COUNT_ZERO) & ~cmd_reload;
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            count_r <= iwd_pkg::RELOAD_RESET;
            reset_req_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            reset_req_r <= reset_req_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign WDG_RESET_OUT = reset_req_r;
    assign WDG_RUNNING_OUT = enabled_r;
endmodule

//--- iwd_watchdog_monitor.sv
// iwd_watchdog_monitor: port-level assertions of the watchdog
// assumes: bound to iwd_watchdog, hready tied to hreadyout
`timescale 1ns/100ps
module iwd_watchdog_monitor (
    // clock, reset, bus
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    // debug and watchdog state
    input wire logic CORE_HALTED_IN,
    input wire logic DEBUG_FREEZE_IN,
    input wire logic WDG_RESET_OUT,
    input wire logic WDG_RUNNING_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic taken;
    logic cmd_ph_r;
    logic cmd_ph_nxt;
    logic start_ph;
    logic reload_ph;
    logic frz_ok;
    // command data phase follows a taken write to offset 0
    assign taken = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign start_ph = cmd_ph_r && (HWDATA_IN[15:0] == iwd_pkg::CMD_START);
    assign reload_ph = cmd_ph_r && (HWDATA_IN[15:0] == iwd_pkg::CMD_RELOAD);
    assign frz_ok = CORE_HALTED_IN && DEBUG_FREEZE_IN && !WDG_RESET_OUT && !cmd_ph_r;
    always_comb begin
        // byte writes are dropped by the slave, so only half-word and word count
        cmd_ph_nxt = taken && HWRITE_IN && (HADDR_IN[11:0] == 12'h000)
            && (HSIZE_IN == iwd_pkg::HSIZE_HALF || HSIZE_IN == iwd_pkg::HSIZE_WORD);
    end
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cmd_ph_r <= 1'b0;
        end else begin
            cmd_ph_r <= cmd_ph_nxt;
        end
    end
    // --------------------------------------------------------
    // assertions
    // --------------------------------------------------------
    sequence rd_taken;
        taken && !HWRITE_IN;
    endsequence
    sequence rd_answer;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    a_resp_okay: assert property (HRESP_OUT == 1'b0) else $error("response not okay");
    a_read_wait: assert property (rd_taken |=> rd_answer) else $error("read wait state wrong");
    a_write_nowait: assert property (taken && HWRITE_IN |=> HREADYOUT_OUT) else $error("write stalled");
    a_rdata_stands: assert property ($changed(HRDATA_OUT) |-> $past(taken && !HWRITE_IN, 2))
        else $error("read data moved without a read");
    a_start_enables: assert property (start_ph |=> WDG_RUNNING_OUT) else $error("start ignored");
    a_run_sticky: assert property (WDG_RUNNING_OUT |=> WDG_RUNNING_OUT) else $error("enable dropped");
    a_reset_needs_run: assert property (WDG_RESET_OUT |-> WDG_RUNNING_OUT) else $error("reset while off");
    a_reset_holds: assert property (WDG_RESET_OUT && !reload_ph |=> WDG_RESET_OUT) else $error("reset fell");
    a_reload_clears: assert property (reload_ph |=> !WDG_RESET_OUT) else $error("reload kept reset");
    a_freeze_holds: assert property (frz_ok [*3] |=> !WDG_RESET_OUT) else $error("counted while frozen");
endmodule
bind iwd_watchdog iwd_watchdog_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
    .HSIZE_IN(HSIZE_IN),
    .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .CORE_HALTED_IN(CORE_HALTED_IN), .DEBUG_FREEZE_IN(DEBUG_FREEZE_IN), .WDG_RESET_OUT(WDG_RESET_OUT),
    .WDG_RUNNING_OUT(WDG_RUNNING_OUT));

//--- iwd_watchdog_bench.sv
// iwd_watchdog_bench: self-checking bench of the watchdog over ahb-lite
// assumes: slow oscillator sped up to one tick per 4 clocks to keep runs short
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module iwd_watchdog_bench;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, osc = 1'b0, osc_en = 1'b1;
    logic opt = 1'b0, halted = 1'b0, frz = 1'b0, rdy, hresp, wrst, wrun;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    int n_mismatch = 0, n_checks = 0, n = 0, ex = 0, osc_cnt = 0;
    iwd_watchdog u_iwd_watchdog (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(rdy),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp), .SLOW_OSC_IN(osc),
        .HW_WDG_OPT_IN(opt), .CORE_HALTED_IN(halted), .DEBUG_FREEZE_IN(frz), .WDG_RESET_OUT(wrst),
        .WDG_RUNNING_OUT(wrun));
    // --------------------------------------------------------
    // clock, slow oscillator and bus tasks
    // --------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    // slow oscillator can be held still so busy flags stay readable;
    // its own counter, so cycle timing below cannot disturb it
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 1;
        if (osc_en && osc_cnt[0]) osc <= ~osc;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // waits for hready at a rising edge, sampled just before it
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            if (rdy === 1'b1) break;
        end
        if (i == 50) begin
            n_mismatch++;
            results();
        end
        v = hrdata;
        @(posedge clk);
    endtask
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0, 3'h2);
        `CHK(v, e)
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 40; i++) begin
            xfer(12'hc, 1'b0, 32'h0, 3'h2);
            if (v === 32'h0) break;
        end
        `CHK(v, 32'h0)
        if (v !== 32'h0) results();
    endtask
    // counts cycles until the watchdog reset rises, then realigns to a rising edge
    task automatic time_rst;
        for (n = 0; n < 3000 && wrst !== 1'b1; n++) @(negedge clk);
        if (wrst !== 1'b1) begin
            n_mismatch++;
            results();
        end
        @(posedge clk);
    endtask
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(12'h4, 32'h0);
        rd_chk(12'h8, 32'hfff);
        rd_chk(12'hc, 32'h0);
        rd_chk(12'h0, 32'h0);
        rd_chk(12'h10, 32'h0);
        `CHK(wrun, 1'b0)
        xfer(12'h8, 1'b1, 32'h5, 3'h2);
        rd_chk(12'h8, 32'hfff);
        $display("reset and lock test done");
        osc_en <= 1'b0;
        xfer(12'h0, 1'b1, 32'h5555, 3'h1);
        xfer(12'h8, 1'b1, 32'h2, 3'h1);
        rd_chk(12'hc, 32'h2);
        rd_chk(12'h8, 32'h2);
        osc_en <= 1'b1;
        wait_idle();
        xfer(12'h0, 1'b1, 32'h1234, 3'h2);
        xfer(12'h8, 1'b1, 32'h7, 3'h2);
        rd_chk(12'h8, 32'h2);
        xfer(12'h0, 1'b1, 32'hcccc, 3'h2);
        @(negedge clk);
        `CHK(wrun, 1'b1)
        @(posedge clk);
        $display("update and start test done");
        halted <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            xfer(12'h0, 1'b1, 32'h5555, 3'h2);
            xfer(12'h4, 1'b1, c, 3'h2);
            wait_idle();
            rd_chk(12'h4, c);
            xfer(12'h0, 1'b1, 32'haaaa, 3'h2);
            @(negedge clk);
            `CHK(wrst, 1'b0)
            @(posedge clk);
            time_rst();
            ex = (c >= 6 ? 256 : 4 << c) * 2 * 4;
            `CHK(n >= ex - 12 && n <= ex + 12, 1'b1)
        end
        $display("divider test done");
        frz <= 1'b1;
        xfer(12'h0, 1'b1, 32'haaaa, 3'h2);
        repeat (300) @(posedge clk);
        `CHK(wrst, 1'b0)
        frz <= 1'b0;
        time_rst();
        `CHK(wrst, 1'b1)
        // the mid-run reset stands in for low-power entry: busy clear, then a quiet gap
        wait_idle();
        repeat (1000) @(posedge clk);
        opt <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(12'h8, 32'hfff);
        `CHK(wrun, 1'b1)
        $display("freeze and option test done");
        results();
    end
endmodule
